/* src/sbec_regs.vh */
// Register indices, field positions, reset values and codes of the event counter
`ifndef SBEC_REGS_VH
`define SBEC_REGS_VH

// Register indices; the byte address is four times the index
`define SBEC_IDX_FLAG     10'h00c
`define SBEC_IDX_LOW      10'h00e
`define SBEC_IDX_HIGH     10'h00f
`define SBEC_IDX_CTRL     10'h010
`define SBEC_IDX_IRQEN    10'h08c

// Control register fields
`define SBEC_CTRL_W       6
`define SBEC_CTRL_RUN     0
`define SBEC_CTRL_CS      1
`define SBEC_CTRL_SYNCDIS 2
`define SBEC_CTRL_OSCEN   3
`define SBEC_CTRL_PS_LO   4
`define SBEC_CTRL_PS_HI   5
`define SBEC_CTRL_RST     6'h00

// Flag and enable registers
`define SBEC_FLAG_OVF     0
`define SBEC_FLAG_RST     1'b0
`define SBEC_IRQEN_RST    1'b0

// Compare mode code that makes a special event trigger
`define SBEC_SPECIAL_TRIG 4'hb

// Phases of the four-phase instruction cycle that sample the prescaler
`define SBEC_PH_Q2        2'h1
`define SBEC_PH_Q4        2'h3

// Prescaler stages and reset values of internal state
`define SBEC_PRESC_W      3
`define SBEC_PRESC_RST    3'h0
`define SBEC_PHASE_RST    2'h0
`define SBEC_RDATA_RST    32'h0000_0000

`endif

/* src/sbec_pin_sync.v */
// Three-stage pin synchroniser whose output moves once stages two and three agree
`default_nettype none

module sbec_pin_sync #(
  parameter WIDTH = 2
) (
  input  wire             pclk,
  input  wire             presetn,
  input  wire [WIDTH-1:0] pin_in,
  output wire [WIDTH-1:0] pin_level
);

  reg [WIDTH-1:0] s1_r;
  reg [WIDTH-1:0] s2_r;
  reg [WIDTH-1:0] s3_r;
  reg [WIDTH-1:0] lvl_r;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      // First stage feeds only the second; metastability settles there
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          s1_r[i]  <= 1'b0;
          s2_r[i]  <= 1'b0;
          s3_r[i]  <= 1'b0;
          lvl_r[i] <= 1'b0;
        end else begin
          s1_r[i] <= pin_in[i];
          s2_r[i] <= s1_r[i];
          s3_r[i] <= s2_r[i];
          if (s2_r[i] == s3_r[i]) begin
            lvl_r[i] <= s3_r[i];
          end
        end
      end
    end
  endgenerate

  assign pin_level = lvl_r;

endmodule

`default_nettype wire

/* src/sbec_counter.v */
// Sixteen-bit event counter with prescaler, phase synchroniser and APB registers
`default_nettype none

`include "sbec_regs.vh"

// Operation
// (R1) Count source: oscillator pin or external pin
// (R2) Sync after ripple prescaler unless disabled
// (R3) Synced mode in sleep: prescaler only
// (R4) Sample prescaler on Q2 and Q4, delayed
// (R5) Source holds 2Tosc high, 2Tosc low
// (R6) Source period at least 4Tosc over prescale
// (R7) Async mode counts in sleep, wakes core
// (R8) Async mode is no compare time base
// (R9) Byte reads always return valid values
// (R10) Software re-reads high byte after low
// (R11) Software stops counter before writing bytes
// (R12) Oscillator enable starts crystal amplifier, sleep-proof
// (R13) Software waits oscillator start-up delay
// (R14) Compare special event trigger clears counter
// (R15) Trigger clear never sets overflow flag
// (R16) Trigger clear unreliable in async mode
// (R17) Byte write beats simultaneous trigger clear
// (R18) Compare pair acts as counter period
// (R19) Reset never clears the count bytes
// (R20) Control clears on power-on reset only
// (R21) Wrap FFFFh to 0000h, latch overflow flag
// (R22) Byte writes clear prescaler count
// (R23) Prescale 1/2/4/8 and run enable gate
module sbec_counter (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        ext_count_pin,
  input  wire        osc_input_pin,
  output wire        osc_output_pin_o,
  output wire        osc_output_pin_oe,
  input  wire        sleep,
  input  wire [3:0]  compare_mode_code_a,
  input  wire        trig_a,
  input  wire [3:0]  compare_mode_code_b,
  input  wire        trig_b,
  output wire [15:0] count_value,
  output wire        timebase_valid,
  output wire        overflow_irq,
  output wire        wake_req
);

  // Register decode against an index; low address bits must be zero
  function hit;
    input [11:0] addr;
    input [9:0]  idx;
    begin
      hit = (addr[11:2] == idx) && (addr[1:0] == 2'b00);
    end
  endfunction

  // Compare unit configured for special event trigger
  function is_special;
    input [3:0] mode;
    begin
      is_special = (mode == `SBEC_SPECIAL_TRIG);
    end
  endfunction

  reg  [`SBEC_CTRL_W-1:0]  ctrl_r;
  reg                      flag_r;
  reg                      flag_nxt;
  reg                      irq_en_r;
  reg  [31:0]              prdata_r;
  reg  [31:0]              rd_mux;
  reg  [15:0]              cnt_r;
  reg  [15:0]              cnt_nxt;
  reg                      ovf_set;
  reg  [`SBEC_PRESC_W-1:0] presc_r;
  reg                      presc_out;
  reg                      src_prev_r;
  reg                      pout_prev_r;
  reg  [1:0]               phase_r;
  reg                      samp_r;
  reg                      sync_rise_r;
  reg                      tbase_r;
  reg                      irq_r;
  reg                      wake_r;
  reg                      osc_drv_r;

  wire [1:0]               pin_lvl;
  wire                     acc;
  wire                     wr;
  wire                     rd_setup;
  wire                     sel_ctrl;
  wire                     sel_low;
  wire                     sel_high;
  wire                     sel_flag;
  wire                     sel_irqen;
  wire                     mapped;
  wire                     wr_ctrl;
  wire                     wr_low;
  wire                     wr_high;
  wire                     wr_flag;
  wire                     wr_irqen;
  wire                     run;
  wire                     cs;
  wire                     sync_dis;
  wire                     osc_en;
  wire [1:0]               ps_sel;
  wire                     async_mode;
  wire                     counting;
  wire                     src_lvl;
  wire                     src_rise;
  wire                     async_rise;
  wire                     sample_now;
  wire                     incr;
  wire                     trig_clr;
  wire                     trig_hit_a;
  wire                     trig_hit_b;
  wire [`SBEC_PRESC_W-1:0] presc_tog;

  // APB decode; zero wait states
  assign acc       = psel & penable;
  assign wr        = acc & pwrite;
  assign rd_setup  = psel & ~penable & ~pwrite;
  assign sel_ctrl  = hit(paddr, `SBEC_IDX_CTRL);
  assign sel_low   = hit(paddr, `SBEC_IDX_LOW);
  assign sel_high  = hit(paddr, `SBEC_IDX_HIGH);
  assign sel_flag  = hit(paddr, `SBEC_IDX_FLAG);
  assign sel_irqen = hit(paddr, `SBEC_IDX_IRQEN);
  assign mapped    = sel_ctrl | sel_low | sel_high | sel_flag | sel_irqen;
  assign wr_ctrl   = wr & sel_ctrl;
  assign wr_low    = wr & sel_low;
  assign wr_high   = wr & sel_high;
  assign wr_flag   = wr & sel_flag;
  assign wr_irqen  = wr & sel_irqen;
  assign pready    = 1'b1;
  assign pslverr   = acc & ~mapped;

  // Control fields
  assign run        = ctrl_r[`SBEC_CTRL_RUN];
  assign cs         = ctrl_r[`SBEC_CTRL_CS];
  assign sync_dis   = ctrl_r[`SBEC_CTRL_SYNCDIS];
  assign osc_en     = ctrl_r[`SBEC_CTRL_OSCEN];
  assign ps_sel     = ctrl_r[`SBEC_CTRL_PS_HI:`SBEC_CTRL_PS_LO];
  assign async_mode = cs & sync_dis;
  assign counting   = run & cs; // R23

  // Power-on reset is the only reset that reaches the control register
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r   <= `SBEC_CTRL_RST; // R20
      irq_en_r <= `SBEC_IRQEN_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_r <= pwdata[`SBEC_CTRL_W-1:0];
      end
      if (wr_irqen) begin
        irq_en_r <= pwdata[0];
      end
    end
  end

  // Both pins pass the three-stage synchroniser
  sbec_pin_sync #(
    .WIDTH     (2)
  ) u_pin_sync (
    .pclk      (pclk),
    .presetn   (presetn),
    .pin_in    ({osc_input_pin, ext_count_pin}),
    .pin_level (pin_lvl)
  );

  assign src_lvl  = osc_en ? pin_lvl[1] : pin_lvl[0]; // R1
  assign src_rise = src_lvl & ~src_prev_r;

  // Ripple chain on one clock: a stage toggles as the stage below falls
  // Stage zero toggles on every counted rise of the source
  genvar g;
  generate
    for (g = 0; g < `SBEC_PRESC_W; g = g + 1) begin : g_presc
      if (g == 0) begin : g_first
        assign presc_tog[g] = counting & src_rise; // R2
      end else begin : g_next
        assign presc_tog[g] = presc_tog[g-1] & presc_r[g-1];
      end
    end
  endgenerate

  // Ripple prescaler keeps counting in sleep
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc_r    <= `SBEC_PRESC_RST;
      src_prev_r <= 1'b0;
    end else begin
      src_prev_r <= src_lvl;
      if (wr_low | wr_high) begin
        presc_r <= `SBEC_PRESC_RST; // R22
      end else begin
        presc_r <= presc_r ^ presc_tog; // R2 R3
      end
    end
  end

  // Each stage toggles, so a chosen stage output stays symmetrical; setting 0 passes the source level unchanged
  always @* begin
    case (ps_sel)
      2'h0:    presc_out = src_lvl; // R23
      2'h1:    presc_out = presc_r[0];
      2'h2:    presc_out = presc_r[1];
      2'h3:    presc_out = presc_r[2];
      default: presc_out = src_lvl;
    endcase
  end

  // Phase sampling; input must be stable over both samples
  assign sample_now = ~sleep & ((phase_r == `SBEC_PH_Q2) | (phase_r == `SBEC_PH_Q4)); // R4 R5 R6
  assign async_rise = presc_out & ~pout_prev_r;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_r     <= `SBEC_PHASE_RST;
      samp_r      <= 1'b0;
      sync_rise_r <= 1'b0;
      pout_prev_r <= 1'b0;
    end else begin
      phase_r     <= phase_r + 2'h1;
      pout_prev_r <= presc_out;
      // Synchroniser is off in sleep, so no synced edge is seen there
      sync_rise_r <= sample_now & presc_out & ~samp_r; // R3 R4
      if (sample_now) begin
        samp_r <= presc_out;
      end else if (sleep) begin
        // Edges that arrive in sleep are dropped, not counted on wake-up
        samp_r <= presc_out; // R3
      end
    end
  end

  // Async edges bypass the phase sampler and keep running in sleep
  assign incr = counting & (sync_dis ? async_rise : sync_rise_r); // R2 R7

  // Each unit decodes its own mode, so a pulse from a unit in another mode is ignored
  assign trig_hit_a = trig_a & is_special(compare_mode_code_a); // R14
  assign trig_hit_b = trig_b & is_special(compare_mode_code_b); // R14

  // Clear is withheld in async mode, where it cannot be relied on
  assign trig_clr = (trig_hit_a | trig_hit_b) & ~async_mode; // R14 R16

  always @* begin
    cnt_nxt = cnt_r;
    ovf_set = 1'b0;
    if (wr_low | wr_high) begin
      // An increment in the same cycle is dropped; software should stop first
      if (wr_low) begin
        cnt_nxt[7:0] = pwdata[7:0]; // R11 R17
      end
      if (wr_high) begin
        cnt_nxt[15:8] = pwdata[7:0]; // R17
      end
    end else if (trig_clr) begin
      cnt_nxt = 16'h0000; // R14 R15 R18
    end else if (incr) begin
      cnt_nxt = cnt_r + 16'h0001; // R21
      ovf_set = (cnt_r == 16'hffff); // R21
    end
  end

  // Count bytes carry no reset at all
  always @(posedge pclk) begin
    cnt_r <= cnt_nxt; // R19
  end

  // Hardware set wins over a software clear in the same cycle
  always @* begin
    flag_nxt = flag_r;
    if (wr_flag) begin
      flag_nxt = pwdata[`SBEC_FLAG_OVF];
    end
    if (ovf_set) begin
      flag_nxt = 1'b1; // R21
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_r    <= `SBEC_FLAG_RST;
      irq_r     <= 1'b0;
      wake_r    <= 1'b0;
      tbase_r   <= 1'b0;
      osc_drv_r <= 1'b0;
    end else begin
      flag_r    <= flag_nxt;
      irq_r     <= flag_r & irq_en_r; // R21
      wake_r    <= flag_r & irq_en_r & sleep; // R7
      tbase_r   <= ~async_mode; // R8
      // Amplifier output ignores sleep so the crystal keeps running
      osc_drv_r <= osc_en & ~pin_lvl[1]; // R12
    end
  end

  // Read data captured in setup; single clock means bytes are never torn
  always @* begin
    rd_mux = 32'h0000_0000;
    if (sel_ctrl) begin
      rd_mux[`SBEC_CTRL_W-1:0] = ctrl_r;
    end else if (sel_low) begin
      rd_mux[7:0] = cnt_r[7:0]; // R9
    end else if (sel_high) begin
      rd_mux[7:0] = cnt_r[15:8]; // R9 R10
    end else if (sel_flag) begin
      rd_mux[`SBEC_FLAG_OVF] = flag_r;
    end else if (sel_irqen) begin
      rd_mux[0] = irq_en_r;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= `SBEC_RDATA_RST;
    end else if (rd_setup) begin
      prdata_r <= rd_mux;
    end
  end

  assign prdata            = prdata_r;
  assign count_value       = cnt_r;
  assign timebase_valid    = tbase_r;
  assign overflow_irq      = irq_r;
  assign wake_req          = wake_r;
  assign osc_output_pin_o  = osc_drv_r;
  assign osc_output_pin_oe = osc_en; // R12

endmodule

`default_nettype wire

/* bench/sbec_counter_sva.sv */
// Port checks for the event counter
`default_nettype none
module sbec_counter_sva (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pslverr,
  input wire logic        osc_output_pin_o,
  input wire logic        osc_output_pin_oe,
  input wire logic        sleep,
  input wire logic [3:0]  compare_mode_code_a,
  input wire logic        trig_a,
  input wire logic [3:0]  compare_mode_code_b,
  input wire logic        trig_b,
  input wire logic [15:0] count_value,
  input wire logic        timebase_valid,
  input wire logic        overflow_irq,
  input wire logic        wake_req
);
  timeunit 1ns;
  timeprecision 1ns;
  // Count bytes have no reset, so step checks wait until both are written
  logic [1:0] known_r = 2'h0;
  always @(posedge pclk) begin
    if (psel && penable && pwrite && paddr[11:3] == 9'h007) begin
      known_r[paddr[2]] <= 1'b1;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_trig;
    (trig_a && compare_mode_code_a == 4'hb || trig_b && compare_mode_code_b == 4'hb)
      && timebase_valid;
  endsequence
  sequence s_byte_wr;
    psel && penable && pwrite && (paddr == 12'h038 || paddr == 12'h03c);
  endsequence
  property p_trig_clr;
    s_trig ##0 !psel |=> count_value == 16'h0;
  endproperty
  property p_wr_wins;
    s_byte_wr ##0 s_trig ##0 paddr == 12'h038 |=> count_value[7:0] == $past(pwdata[7:0]);
  endproperty
  property p_no_flag;
    s_trig ##0 (!psel && !overflow_irq && count_value != 16'hffff && count_value != 16'h0)
      |=> ##1 !overflow_irq;
  endproperty
  property p_step;
    !(psel && pwrite) && &known_r |=> count_value == $past(count_value) ||
      count_value == $past(count_value) + 16'h1 || count_value == 16'h0;
  endproperty
  property p_sleep;
    (sleep && timebase_valid && !psel && !trig_a && !trig_b && &known_r)[*4]
      |-> $stable(count_value);
  endproperty
  property p_osc_oe;
    $fell(osc_output_pin_oe) |=> !osc_output_pin_o;
  endproperty
  property p_wake;
    wake_req |-> overflow_irq && $past(sleep);
  endproperty
  property p_err;
    psel && penable && paddr[1:0] != 2'h0 |-> pslverr;
  endproperty
  a_trig_clr: assert property (p_trig_clr) else $error("trigger did not clear count");
  a_wr_wins: assert property (p_wr_wins) else $error("write lost to trigger");
  a_no_flag: assert property (p_no_flag) else $error("trigger raised overflow");
  a_step: assert property (p_step) else $error("count moved by more than one");
  a_sleep: assert property (p_sleep) else $error("count moved in synced sleep");
  a_osc_oe: assert property (p_osc_oe) else $error("oscillator drive after disable");
  a_wake: assert property (p_wake) else $error("wake without irq in sleep");
  a_err: assert property (p_err) else $error("misaligned access not refused");
endmodule
bind sbec_counter sbec_counter_sva sbec_counter_sva_inst (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pslverr, .osc_output_pin_o, .osc_output_pin_oe, .sleep,
  .compare_mode_code_a, .trig_a, .compare_mode_code_b, .trig_b, .count_value,
  .timebase_valid, .overflow_irq, .wake_req);
`default_nettype wire

/* bench/sbec_src_model.sv */
// External count source or crystal driving one of the two count pins
`default_nettype none
module sbec_src_model #(
  parameter int HALF = 4
) (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       go,
  input  wire logic       sel,
  input  wire logic [7:0] n,
  output logic            ext_pin,
  output logic            osc_pin,
  output logic            busy
);
  timeunit 1ns;
  timeprecision 1ns;
  // Levels held four pclk at least, so both sampling phases see them
  localparam int H = (HALF < 4) ? 4 : HALF;
  logic [7:0] left_r;
  logic [7:0] cnt_r;
  logic       lvl_r;
  logic       sel_r;
  assign ext_pin = lvl_r & ~sel_r;
  assign osc_pin = lvl_r & sel_r;
  assign busy = left_r != 8'h0;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      left_r <= 8'h0;
      cnt_r <= 8'h0;
      lvl_r <= 1'b0;
      sel_r <= 1'b0;
    end else if (go && !busy) begin
      left_r <= n;
      sel_r <= sel;
      cnt_r <= 8'h0;
    end else if (busy) begin
      if (cnt_r != 8'h0) begin
        cnt_r <= cnt_r - 8'h1;
      end else begin
        lvl_r <= ~lvl_r;
        cnt_r <= 8'(H - 1);
        if (lvl_r) left_r <= left_r - 8'h1;
      end
    end
  end
endmodule
`default_nettype wire

/* bench/tb_sbec_counter.sv */
// Directed testbench for the event counter
`default_nettype none
module tb_sbec_counter;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [11:0] ad_flag = 12'h030, ad_lo = 12'h038, ad_hi = 12'h03c;
  localparam logic [11:0] ad_ctrl = 12'h040, ad_irq = 12'h230;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, err, ext_count_pin, osc_input_pin;
  logic        osc_output_pin_o, osc_output_pin_oe, timebase_valid, overflow_irq, wake_req;
  logic        sleep = 1'b0, trig_a = 1'b0, trig_b = 1'b0, go = 1'b0, sel = 1'b0, busy;
  logic [3:0]  compare_mode_code_a = 4'h0, compare_mode_code_b = 4'h0;
  logic [7:0]  n = 8'h0;
  logic [15:0] count_value;
  int          errors = 0, total_checks = 0;
  always #50 pclk = ~pclk;
  sbec_counter sbec_counter_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .ext_count_pin, .osc_input_pin, .osc_output_pin_o,
    .osc_output_pin_oe, .sleep, .compare_mode_code_a, .trig_a, .compare_mode_code_b, .trig_b,
    .count_value, .timebase_valid, .overflow_irq, .wake_req);
  sbec_src_model sbec_src_model_inst (.pclk, .presetn, .go, .sel, .n,
    .ext_pin(ext_count_pin), .osc_pin(osc_input_pin), .busy);
  task automatic close_out;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rw(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (pready !== 1'b1) begin
      errors++;
      close_out();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic setc(input logic [15:0] v);
    rw(1'b1, ad_lo, {24'h0, v[7:0]});
    rw(1'b1, ad_hi, {24'h0, v[15:8]});
  endtask
  task automatic src(input logic s, input logic [7:0] k);
    int i;
    @(posedge pclk);
    go <= 1'b1;
    sel <= s;
    n <= k;
    @(posedge pclk);
    go <= 1'b0;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (busy && i < 400);
    if (busy) begin
      errors++;
      close_out();
    end
    repeat (12) @(posedge pclk);
  endtask
  task automatic trg(input logic b);
    @(posedge pclk);
    if (b) trig_b <= 1'b1;
    else trig_a <= 1'b1;
    @(posedge pclk);
    trig_a <= 1'b0;
    trig_b <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rw(1'b0, ad_ctrl, 32'h0);
    chk(rd, 32'h0);
    setc(16'hfffd);
    rw(1'b1, ad_irq, 32'h1);
    rw(1'b1, ad_ctrl, 32'h3);
    src(1'b0, 8'h4);
    chk(count_value, 32'h1);
    chk(overflow_irq, 32'h1);
    rw(1'b0, ad_hi, 32'h0);
    chk(rd, 32'h0);
    rw(1'b0, ad_lo, 32'h0);
    chk(rd, 32'h1);
    for (int p = 0; p < 4; p++) begin
      rw(1'b1, ad_ctrl, 32'h0);
      setc(16'h0);
      rw(1'b1, ad_ctrl, 32'h3 | (p << 4));
      src(1'b0, 8'h8);
      chk(count_value, 32'h8 >> p);
    end
    rw(1'b1, ad_ctrl, 32'h2);
    src(1'b0, 8'h4);
    chk(count_value, 32'h1);
    rw(1'b1, ad_ctrl, 32'h3);
    sleep <= 1'b1;
    src(1'b0, 8'h4);
    chk(count_value, 32'h1);
    rw(1'b1, ad_flag, 32'h0);
    rw(1'b1, ad_ctrl, 32'h0);
    setc(16'hfffe);
    rw(1'b1, ad_ctrl, 32'h7);
    src(1'b0, 8'h4);
    chk(count_value, 32'h2);
    chk(wake_req, 32'h1);
    chk(timebase_valid, 32'h0);
    compare_mode_code_a <= 4'hb;
    trg(1'b0);
    chk(count_value, 32'h2);
    sleep <= 1'b0;
    rw(1'b1, ad_flag, 32'h0);
    rw(1'b1, ad_ctrl, 32'hb);
    repeat (20) @(posedge pclk);
    chk(osc_output_pin_oe, 32'h1);
    chk(osc_output_pin_o, 32'h1);
    src(1'b1, 8'h4);
    chk(count_value, 32'h6);
    trg(1'b0);
    chk(count_value, 32'h0);
    rw(1'b0, ad_flag, 32'h0);
    chk(rd, 32'h0);
    setc(16'h1234);
    compare_mode_code_b <= 4'hb;
    trg(1'b1);
    chk(count_value, 32'h0);
    compare_mode_code_a <= 4'ha;
    setc(16'h1234);
    trg(1'b0);
    chk(count_value, 32'h1234);
    compare_mode_code_a <= 4'hb;
    trig_a <= 1'b1;
    rw(1'b1, ad_lo, 32'h55);
    trig_a <= 1'b0;
    @(posedge pclk);
    chk(count_value, 32'h55);
    rw(1'b1, ad_ctrl, 32'h3);
    rw(1'b0, 12'h100, 32'h0);
    chk(err, 32'h1);
    rw(1'b1, 12'h041, 32'h0);
    rw(1'b0, ad_ctrl, 32'h0);
    chk(rd, 32'h3);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rw(1'b0, ad_ctrl, 32'h0);
    chk(rd, 32'h0);
    chk(count_value, 32'h55);
    close_out();
  end
endmodule
`default_nettype wire
